// ### rtl/capture_timer_consts.vh
// Constants of the dual input-capture timer: register map and field codes.
// Assumes a byte-addressed APB slave with one 32-bit word per register.
`ifndef CAPTURE_TIMER_CONSTS_VH
`define CAPTURE_TIMER_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ADDR_MODULE_STOP   8'h00
`define ADDR_START         8'h04
`define ADDR_MODE          8'h08
`define ADDR_FUNC_CTRL     8'h0c
`define ADDR_CH_CTRL0      8'h10
`define ADDR_CH_CTRL1      8'h14
`define ADDR_IO_SEL0       8'h18
`define ADDR_IO_SEL1       8'h1c
`define ADDR_COUNTER0      8'h20
`define ADDR_COUNTER1      8'h24
`define ADDR_STATUS0       8'h28
`define ADDR_STATUS1       8'h2c
`define ADDR_INT_EN0       8'h30
`define ADDR_INT_EN1       8'h34
`define ADDR_GR_BASE       8'h40
`define ADDR_GR_LAST       8'h5c

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define CTRL_CLK_LSB       0
`define CTRL_CLR_LSB       4
`define FCR_EXT_EN_BIT     0
`define FCR_FAST40_BIT     1
`define STAT_OVF_BIT       4
`define STAT_W             5
`define IO_EDGE_LSB        2

// ----------------------------------------------------------------------
// Count clock select codes
// ----------------------------------------------------------------------
`define CKS_SYS            3'h0
`define CKS_DIV2           3'h1
`define CKS_DIV4           3'h2
`define CKS_DIV8           3'h3
`define CKS_DIV32          3'h4
`define CKS_FAST           3'h5
`define CKS_EXT            3'h6

// ----------------------------------------------------------------------
// Counter clear select codes and capture edge codes
// ----------------------------------------------------------------------
`define CLR_NONE_A         3'h0
`define CLR_NONE_B         3'h4
`define CLR_SYNC_A         3'h3
`define CLR_SYNC_B         3'h7
`define EDGE_RISE          2'h0
`define EDGE_FALL          2'h1
`define EDGE_BOTH          2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BIT            1'h0
`define RST_BYTE           8'h00
`define RST_WORD           32'h00000000

`endif

// ### rtl/count_clock_select.v
// Count clock selection: prescaled system clock, fast oscillator, external.
// Assumes fast_tick and ext_tick are synchronised one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_consts.vh"

module count_clock_select
#(
	parameter PRE_W = 5
)
(
	input  wire       sys_clk,
	input  wire       rst,
	input  wire       clk_on,
	input  wire [2:0] clk_sel,
	input  wire       ext_en,
	input  wire       fast_tick,
	input  wire       ext_tick,
	output reg        tick
);

reg [PRE_W-1:0] pre_ff;

always @(posedge sys_clk)
begin
	if (rst || !clk_on)
		pre_ff <= {PRE_W{1'b0}};
	else
		pre_ff <= pre_ff + 1'b1;
end

always @*
begin
	case (clk_sel)
		`CKS_SYS:   tick = 1'b1;                 // R2
		`CKS_DIV2:  tick = pre_ff[0];
		`CKS_DIV4:  tick = &pre_ff[1:0];
		`CKS_DIV8:  tick = &pre_ff[2:0];
		`CKS_DIV32: tick = &pre_ff[4:0];
		`CKS_FAST:  tick = fast_tick;
		`CKS_EXT:   tick = ext_en & ext_tick;    // R4
		default:    tick = 1'b0;
	endcase
	tick = tick & clk_on;                        // R1
end

endmodule // count_clock_select
`default_nettype wire

// ### rtl/dual_input_capture_timer.v
// Two-channel input-capture timer with an APB register slave.
// Assumes capture pins, fast oscillator and external clock are asynchronous
// and slower than half of sys_clk; APB runs on sys_clk.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_consts.vh"

// Overview of operation
// R1: Module stop bit zero enables clock
// R2: Clock from system, prescaled, fast or external
// R3: Fast oscillator option is 40 or 32 MHz
// R4: External clock needs its enable bit set
// R5: Clear select 000/100 never clears counter
// R6: Clear select 011/111 follows other channel clear
// R7: Other clear selects clear on chosen capture
// R8: Run bit one starts counting up
// R9: Run bit zero stops the counter
// R10: Capture and overflow raise interrupt requests
// R11: Sync zero: independent counters, single load; clear select 011/111 still follows other channel clear
// R12: Sync one: write loads both counters
// R13: Two identical channels, four capture registers each
// R14: Pin and edge selectable per register
// R15: Capture copies counter in same cycle
module dual_input_capture_timer
#(
	parameter CW    = 16,
	parameter PRE_W = 5
)
(
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	input  wire [3:0]  capture_input_pin_ch0,
	input  wire [3:0]  capture_input_pin_ch1,
	input  wire        fast_oscillator_clock,
	input  wire        external_clock,
	output wire        fast_osc_40m_sel,
	output wire        irq_ch0,
	output wire        irq_ch1
);

// ----------------------------------------------------------------------
// Helper functions
// ----------------------------------------------------------------------
function known_addr;
	input [7:0] a;
	begin
		known_addr = (a <= `ADDR_INT_EN1) ||
			((a >= `ADDR_GR_BASE) && (a <= `ADDR_GR_LAST));
		known_addr = known_addr && (a[1:0] == 2'h0);
	end
endfunction

function [CW:0] count_step;
	input [CW-1:0] cnt;
	begin
		count_step = {1'b0, cnt} + {{CW{1'b0}}, 1'b1};
	end
endfunction

// ----------------------------------------------------------------------
// Software registers
// ----------------------------------------------------------------------
reg                      module_stop_bit_ff;
reg  [1:0]               channel_run_bit_ff;
reg                      sync_mode_ff;
reg                      external_clock_enable_bit_ff;
reg                      fast40_ff;
reg  [15:0]              channel_control_register_ff;
reg  [31:0]              io_select_ff;
reg  [2*`STAT_W-1:0]     status_ff;
reg  [2*`STAT_W-1:0]     int_en_ff;

wire                     wr_en;
wire                     rd_setup;
wire                     clk_on;
wire [2*CW-1:0]          cnt_all;
wire [8*CW-1:0]          gr_all;
wire [7:0]               cap_ev;
wire [1:0]               clr_cap;
wire [1:0]               ovf_ev;
wire [7:0]               pin_rise;
wire [7:0]               pin_fall;
wire                     fast_tick;
wire                     ext_tick;

assign wr_en    = psel & penable & pwrite;
assign rd_setup = psel & ~penable;
assign pready   = 1'b1;
assign clk_on   = ~module_stop_bit_ff;                 // R1
assign fast_osc_40m_sel = fast40_ff;                   // R3

always @(posedge sys_clk)
begin
	if (rst)
	begin
		module_stop_bit_ff           <= `RST_BIT;
		channel_run_bit_ff           <= 2'h0;
		sync_mode_ff                 <= `RST_BIT;
		external_clock_enable_bit_ff <= `RST_BIT;
		fast40_ff                    <= `RST_BIT;
		channel_control_register_ff  <= 16'h0000;
		io_select_ff                 <= `RST_WORD;
		int_en_ff                    <= {2*`STAT_W{1'b0}};
	end
	else if (wr_en)
	begin
		case (paddr)
			`ADDR_MODULE_STOP: module_stop_bit_ff <= pwdata[0];
			`ADDR_START:   channel_run_bit_ff <= pwdata[1:0]; // R8 R9
			`ADDR_MODE:    sync_mode_ff <= pwdata[0];
			`ADDR_FUNC_CTRL:
			begin
				external_clock_enable_bit_ff <=
					pwdata[`FCR_EXT_EN_BIT];
				fast40_ff <= pwdata[`FCR_FAST40_BIT];
			end
			`ADDR_CH_CTRL0:
				channel_control_register_ff[7:0] <= pwdata[7:0];
			`ADDR_CH_CTRL1:
				channel_control_register_ff[15:8] <= pwdata[7:0];
			`ADDR_IO_SEL0: io_select_ff[15:0]  <= pwdata[15:0];
			`ADDR_IO_SEL1: io_select_ff[31:16] <= pwdata[15:0];
			`ADDR_INT_EN0:
				int_en_ff[`STAT_W-1:0] <= pwdata[`STAT_W-1:0];
			`ADDR_INT_EN1:
				int_en_ff[2*`STAT_W-1:`STAT_W] <=
					pwdata[`STAT_W-1:0];
			default: ;
		endcase
	end
end

// ----------------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------------
genvar p;
generate
	for (p = 0; p < 8; p = p + 1)
	begin : g_pin
		pin_edge_detect u_pin (
			.sys_clk (sys_clk),
			.rst     (rst),
			.pin     ((p < 4) ? capture_input_pin_ch0[p % 4]
				: capture_input_pin_ch1[p % 4]),
			.rise    (pin_rise[p]),
			.fall    (pin_fall[p])
		);
	end
endgenerate

pin_edge_detect u_fast (
	.sys_clk (sys_clk),
	.rst     (rst),
	.pin     (fast_oscillator_clock),
	.rise    (fast_tick),
	.fall    ()
);

pin_edge_detect u_ext (
	.sys_clk (sys_clk),
	.rst     (rst),
	.pin     (external_clock),
	.rise    (ext_tick),
	.fall    ()
);

// ----------------------------------------------------------------------
// Capture events and general capture registers
// ----------------------------------------------------------------------
genvar k;
generate
	for (k = 0; k < 8; k = k + 1)
	begin : g_cap
		wire [1:0]    pin_sel = io_select_ff[k*4 +: 2];       // R14
		wire [1:0]    edg_sel = io_select_ff[k*4+`IO_EDGE_LSB +: 2];
		wire [3:0]    r4 = pin_rise[(k/4)*4 +: 4];
		wire [3:0]    f4 = pin_fall[(k/4)*4 +: 4];
		reg           hit;
		reg  [CW-1:0] general_capture_register_ff;

		always @*
		begin
			case (edg_sel)
				`EDGE_RISE: hit = r4[pin_sel];
				`EDGE_FALL: hit = f4[pin_sel];
				`EDGE_BOTH: hit = r4[pin_sel] | f4[pin_sel];
				default:    hit = 1'b0;
			endcase
		end

		assign cap_ev[k] = hit & clk_on;

		always @(posedge sys_clk)
		begin
			if (rst)
				general_capture_register_ff <= {CW{1'b0}};
			else if (cap_ev[k])                               // R15
				general_capture_register_ff <=
					cnt_all[(k/4)*CW +: CW];
		end

		assign gr_all[k*CW +: CW] = general_capture_register_ff;
	end
endgenerate

// ----------------------------------------------------------------------
// Channels: clock select, clearing and counter
// ----------------------------------------------------------------------
genvar c;
generate
	for (c = 0; c < 2; c = c + 1)                                   // R13
	begin : g_ch
		wire [2:0]    clk_sel = channel_control_register_ff[
			c*8+`CTRL_CLK_LSB +: 3];
		wire [2:0]    clr_sel = channel_control_register_ff[
			c*8+`CTRL_CLR_LSB +: 3];
		wire          no_clr  = (clr_sel == `CLR_NONE_A) ||
			(clr_sel == `CLR_NONE_B);                        // R5
		wire          sync_clr = (clr_sel == `CLR_SYNC_A) ||
			(clr_sel == `CLR_SYNC_B);
		wire [1:0]    clr_idx = {clr_sel[2], clr_sel[1]};
		wire [3:0]    ev4 = cap_ev[c*4 +: 4];
		wire          tick;
		wire          own_wr;
		wire          other_wr;
		wire          do_wr;
		wire          do_clr;
		wire          run;
		wire [CW:0]   inc;
		reg  [CW-1:0] channel_counter_ff;
		reg  [CW-1:0] nxt_channel_counter;

		count_clock_select #(.PRE_W(PRE_W)) u_cks (
			.sys_clk   (sys_clk),
			.rst       (rst),
			.clk_on    (clk_on),
			.clk_sel   (clk_sel),
			.ext_en    (external_clock_enable_bit_ff),
			.fast_tick (fast_tick),
			.ext_tick  (ext_tick),
			.tick      (tick)
		);

		assign clr_cap[c] = ~no_clr & ~sync_clr & ev4[clr_idx]; // R7
		assign do_clr = clr_cap[c] |
			(sync_clr & clr_cap[1-c] & clk_on);              // R6
		assign own_wr = wr_en && (paddr == ((c == 0) ?
			`ADDR_COUNTER0 : `ADDR_COUNTER1));                // R11
		assign other_wr = wr_en && sync_mode_ff &&
			(paddr == ((c == 0) ? `ADDR_COUNTER1 :
			`ADDR_COUNTER0));                                // R12
		assign do_wr = own_wr | other_wr;
		assign run = channel_run_bit_ff[c] & tick;             // R8 R9
		assign inc = count_step(channel_counter_ff);
		assign ovf_ev[c] = run & inc[CW] & ~do_wr & ~do_clr;

		always @*
		begin
			if (do_wr)
				nxt_channel_counter = pwdata[CW-1:0];
			else if (do_clr)
				nxt_channel_counter = {CW{1'b0}};
			else if (run)
				nxt_channel_counter = inc[CW-1:0];
			else
				nxt_channel_counter = channel_counter_ff;
		end

		always @(posedge sys_clk)
		begin
			if (rst)
				channel_counter_ff <= {CW{1'b0}};
			else
				channel_counter_ff <= nxt_channel_counter;
		end

		assign cnt_all[c*CW +: CW] = channel_counter_ff;
	end
endgenerate

// ----------------------------------------------------------------------
// Status flags: set wins over write-one-to-clear
// ----------------------------------------------------------------------
wire [2*`STAT_W-1:0] stat_set;
wire [2*`STAT_W-1:0] stat_clr;

assign stat_set = {ovf_ev[1], cap_ev[7:4], ovf_ev[0], cap_ev[3:0]};
assign stat_clr = {
	(wr_en && paddr == `ADDR_STATUS1) ? pwdata[`STAT_W-1:0]
		: {`STAT_W{1'b0}},
	(wr_en && paddr == `ADDR_STATUS0) ? pwdata[`STAT_W-1:0]
		: {`STAT_W{1'b0}}};

always @(posedge sys_clk)
begin
	if (rst)
		status_ff <= {2*`STAT_W{1'b0}};
	else
		status_ff <= (status_ff & ~stat_clr) | stat_set;     // R10
end

assign irq_ch0 = |(status_ff[`STAT_W-1:0] & int_en_ff[`STAT_W-1:0]);
assign irq_ch1 = |(status_ff[2*`STAT_W-1:`STAT_W] &
	int_en_ff[2*`STAT_W-1:`STAT_W]);                             // R10

// ----------------------------------------------------------------------
// APB read path, sampled in the setup cycle
// ----------------------------------------------------------------------
reg  [31:0] rd_mux;
wire [7:0]  gr_off;

assign gr_off = paddr - `ADDR_GR_BASE;

always @*
begin
	rd_mux = `RST_WORD;
	case (paddr)
		`ADDR_MODULE_STOP: rd_mux[0] = module_stop_bit_ff;
		`ADDR_START:       rd_mux[1:0] = channel_run_bit_ff;
		`ADDR_MODE:        rd_mux[0] = sync_mode_ff;
		`ADDR_FUNC_CTRL:
		begin
			rd_mux[`FCR_EXT_EN_BIT] = external_clock_enable_bit_ff;
			rd_mux[`FCR_FAST40_BIT] = fast40_ff;
		end
		`ADDR_CH_CTRL0: rd_mux[7:0] = channel_control_register_ff[7:0];
		`ADDR_CH_CTRL1: rd_mux[7:0] = channel_control_register_ff[15:8];
		`ADDR_IO_SEL0:  rd_mux[15:0] = io_select_ff[15:0];
		`ADDR_IO_SEL1:  rd_mux[15:0] = io_select_ff[31:16];
		`ADDR_COUNTER0: rd_mux[CW-1:0] = cnt_all[CW-1:0];
		`ADDR_COUNTER1: rd_mux[CW-1:0] = cnt_all[2*CW-1:CW];
		`ADDR_STATUS0:  rd_mux[`STAT_W-1:0] = status_ff[`STAT_W-1:0];
		`ADDR_STATUS1:
			rd_mux[`STAT_W-1:0] = status_ff[2*`STAT_W-1:`STAT_W];
		`ADDR_INT_EN0:  rd_mux[`STAT_W-1:0] = int_en_ff[`STAT_W-1:0];
		`ADDR_INT_EN1:
			rd_mux[`STAT_W-1:0] = int_en_ff[2*`STAT_W-1:`STAT_W];
		default:
		begin
			if (paddr >= `ADDR_GR_BASE && paddr <= `ADDR_GR_LAST)
				rd_mux[CW-1:0] = gr_all[gr_off[4:2]*CW +: CW];
		end
	endcase
end

always @(posedge sys_clk)
begin
	if (rst)
	begin
		prdata  <= `RST_WORD;
		pslverr <= `RST_BIT;
	end
	else if (rd_setup)
	begin
		prdata  <= pwrite ? `RST_WORD : rd_mux;
		pslverr <= ~known_addr(paddr);
	end
end

endmodule // dual_input_capture_timer
`default_nettype wire

// ### rtl/pin_edge_detect.v
// Two-flop synchroniser and edge detector for one asynchronous pin.
// Assumes pin is unrelated to sys_clk; outputs are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_consts.vh"

module pin_edge_detect
(
	input  wire sys_clk,
	input  wire rst,
	input  wire pin,
	output wire rise,
	output wire fall
);

reg meta_ff;
reg sync_ff;
reg last_ff;

always @(posedge sys_clk)
begin
	if (rst)
	begin
		meta_ff <= `RST_BIT;
		sync_ff <= `RST_BIT;
		last_ff <= `RST_BIT;
	end
	else
	begin
		meta_ff <= pin;
		sync_ff <= meta_ff;
		last_ff <= sync_ff;
	end
end

assign rise = sync_ff & ~last_ff;
assign fall = ~sync_ff & last_ff;

endmodule // pin_edge_detect
`default_nettype wire

// ### testbench/capture_timer_chk.sv
// Port checker for the dual input-capture timer, bound to its top module.
// Assumes APB runs on sys_clk and rst is synchronous, active high.
`timescale 1ns/1ps
`default_nettype none
module capture_timer_chk
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        fast_osc_40m_sel,
	input wire logic        irq_ch0,
	input wire logic        irq_ch1
);
	logic [1:0] run_ff;
	wire setup = psel && !penable;
	wire wr_acc = psel && penable && pwrite;
	wire fbit = pwdata[1];
	// Shadow of the run bits, for read-back
	always @(posedge sys_clk)
		if (rst)
			run_ff <= 2'h0;
		else if (wr_acc && paddr == 8'h04)
			run_ff <= pwdata[1:0];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_write_rdzero: assert property (setup && pwrite |=> prdata == 32'h0)
		else $error("write returned read data");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq_ch0 &&
		!irq_ch1 && prdata == 32'h0 && !pslverr && !fast_osc_40m_sel)
		else $error("outputs not cleared by reset");
	a_unmapped_err: assert property (setup && paddr == 8'h38 |=>
		pslverr && prdata == 32'h0) else $error("unmapped access accepted");
	a_mapped_ok: assert property (setup && paddr == 8'h04 |=> !pslverr)
		else $error("mapped access refused");
	a_run_readback: assert property (setup && !pwrite && paddr == 8'h04
		|=> prdata == {30'h0, run_ff}) else $error("run bits read wrong");
	a_fast_select: assert property (wr_acc && paddr == 8'h0c
		|=> fast_osc_40m_sel == $past(fbit)) else $error("fast select wrong");
	a_irq_mask0: assert property (wr_acc && paddr == 8'h30 &&
		pwdata[4:0] == 5'h0 |=> !irq_ch0 [*2]) else $error("irq0 unmasked");
	a_irq_mask1: assert property (wr_acc && paddr == 8'h34 &&
		pwdata[4:0] == 5'h0 |=> !irq_ch1) else $error("irq1 unmasked");
	a_prdata_hold: assert property (!psel |=> $stable(prdata))
		else $error("read data changed while idle");
	c_irq0: cover property (irq_ch0);
	c_irq1: cover property (irq_ch1);
	c_refused: cover property (pslverr);
	c_fast40: cover property (fast_osc_40m_sel);
endmodule // capture_timer_chk
bind dual_input_capture_timer capture_timer_chk chk (.sys_clk, .rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.fast_osc_40m_sel, .irq_ch0, .irq_ch1);
`default_nettype wire

// ### testbench/dual_input_capture_timer_bench.sv
// Self-checking bench for the dual input-capture timer.
// Assumes the register map of capture_timer_consts.vh and zero-wait APB.
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_consts.vh"
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
	num_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module dual_input_capture_timer_bench;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, v, w, seed = 32'd77802;
	logic        pready, pslverr, irq0, irq1, fsel, fast, ext, err;
	logic [3:0]  cap0, cap1;
	int          num_errors = 0;
	int          compares = 0;
	int          e;
	initial forever #2 sys_clk = ~sys_clk;
	dual_input_capture_timer dut (.sys_clk(sys_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_input_pin_ch0(cap0),
		.capture_input_pin_ch1(cap1), .fast_oscillator_clock(fast),
		.external_clock(ext), .fast_osc_40m_sel(fsel), .irq_ch0(irq0),
		.irq_ch1(irq1));
	pin_source_model src (.sys_clk(sys_clk), .cap0(cap0), .cap1(cap1),
		.fast_clk(fast), .ext_clk(ext));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int exp_cnt(int s, int cyc);
		return s == 5 ? cyc * 4 / 25 : cyc / (s == 4 ? 32 : 1 << s);
	endfunction
	task automatic wrap_up();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge sys_clk); n++; end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
		begin
			num_errors++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), x, rd)
	endtask
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (int a = 0; a < 8'h60; a += 4)
		begin
			chk_rd(8'(a), 32'h0);
			`CHK("err", (a == 8'h38 || a == 8'h3c), err)
		end
		// Capture on every register of both channels, counter frozen
		for (int ch = 0; ch < 2; ch++)
			for (int j = 0; j < 4; j++)
			begin
				v = rnd() & 32'hffff;
				e = (ch * 4 + j) % 3;
				wr(8'(`ADDR_COUNTER0 + 4 * ch), v);
				wr(8'(`ADDR_IO_SEL0 + 4 * ch), (32'hcccc & ~(32'hf << 4 * j))
					| (((e << 2) | (3 - j)) << 4 * j));
				wr(8'(`ADDR_INT_EN0 + 4 * ch), 32'h1 << j);
				src.pulse(ch, 3 - j);
				chk_rd(8'(`ADDR_GR_BASE + 16 * ch + 4 * j), v);
				chk_rd(8'(`ADDR_STATUS0 + 4 * ch), 32'h1 << j);
				`CHK("irq", 1'b1, ch ? irq1 : irq0)
				wr(8'(`ADDR_INT_EN0 + 4 * ch), 32'h0);
				`CHK("irq mask", 1'b0, ch ? irq1 : irq0)
				wr(8'(`ADDR_INT_EN0 + 4 * ch), 32'h1 << j);
				wr(8'(`ADDR_STATUS0 + 4 * ch), 32'h1 << j);
				`CHK("irq", 1'b0, ch ? irq1 : irq0)
				chk_rd(8'(`ADDR_STATUS0 + 4 * ch), 32'h0);
			end
		// Count clock choices, start and stop
		for (int s = 0; s < 6; s++)
		begin
			wr(`ADDR_CH_CTRL0, s);
			wr(`ADDR_COUNTER0, 32'h0);
			wr(`ADDR_START, 32'h1);
			repeat (60) @(posedge sys_clk);
			wr(`ADDR_START, 32'h0);
			apb(1'b0, `ADDR_COUNTER0, 32'h0);
			v = rd;
			e = exp_cnt(s, 63);
			`CHK("count", 1'b1, v + 2 >= e && v <= e + 2)
			chk_rd(`ADDR_START, 32'h0);
			chk_rd(`ADDR_COUNTER0, v);
		end
		// External clock only with its enable bit
		for (int x = 0; x < 2; x++)
		begin
			wr(`ADDR_FUNC_CTRL, 3 * x);
			`CHK("fast40", x[0], fsel)
			wr(`ADDR_CH_CTRL0, `CKS_EXT);
			wr(`ADDR_COUNTER0, 32'h0);
			wr(`ADDR_START, 32'h1);
			src.ext_pulses(5);
			wr(`ADDR_START, 32'h0);
			chk_rd(`ADDR_COUNTER0, 5 * x);
		end
		// Module stop freezes counting; overflow sets its flag
		for (int m = 1; m >= 0; m--)
		begin
			wr(`ADDR_CH_CTRL0, `CKS_SYS);
			wr(`ADDR_COUNTER0, 32'hffe0);
			wr(`ADDR_MODULE_STOP, m);
			wr(`ADDR_START, 32'h1);
			repeat (40) @(posedge sys_clk);
			wr(`ADDR_START, 32'h0);
			chk_rd(`ADDR_STATUS0, 32'h10 * (1 - m));
			wr(`ADDR_STATUS0, 32'h1f);
		end
		// Counter writes with and without synchronous operation
		for (int s = 0; s < 2; s++)
		begin
			v = rnd() & 32'hffff;
			w = rnd() & 32'hffff;
			wr(`ADDR_MODE, s);
			wr(`ADDR_COUNTER1, w);
			wr(`ADDR_COUNTER0, v);
			chk_rd(`ADDR_COUNTER1, s ? v : w);
		end
		// Clear by capture, and synchronous clear of the other channel
		wr(`ADDR_IO_SEL0, 32'hccc0);
		wr(`ADDR_CH_CTRL1, 32'h30);
		for (int c = 0; c < 2; c++)
		begin
			wr(`ADDR_CH_CTRL0, c ? 32'h10 : 32'h40);
			wr(`ADDR_COUNTER0, 32'h8000);
			wr(`ADDR_START, 32'h3);
			src.pulse(0, 0);
			wr(`ADDR_START, 32'h0);
			apb(1'b0, `ADDR_COUNTER0, 32'h0);
			`CHK("clr0", c[0], rd < 32'h100)
			apb(1'b0, `ADDR_COUNTER1, 32'h0);
			`CHK("clr1", c[0], rd < 32'h100)
		end
		wrap_up();
	end
endmodule // dual_input_capture_timer_bench
`default_nettype wire

// ### testbench/pin_source_model.sv
// Far-side model: capture pin drivers, fast oscillator, external clock.
// Assumes tasks are called just after a rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_source_model
(
	input  wire logic       sys_clk,
	output var  logic [3:0] cap0,
	output var  logic [3:0] cap1,
	output var  logic       fast_clk,
	output var  logic       ext_clk
);
	initial
	begin
		cap0 = 4'h0;
		cap1 = 4'h0;
		fast_clk = 1'b0;
		ext_clk = 1'b0;
	end
	// Free-running 40 MHz oscillator, unrelated in phase to sys_clk
	// Offset keeps its edges off the sys_clk sampling edges
	initial #0.3 forever #12.5 fast_clk = ~fast_clk;
	task automatic pulse(input int ch, input int pin);
		if (ch != 0) cap1[pin] <= 1'b1; else cap0[pin] <= 1'b1;
		repeat (4) @(posedge sys_clk);
		if (ch != 0) cap1[pin] <= 1'b0; else cap0[pin] <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic ext_pulses(input int n);
		repeat (n)
		begin
			ext_clk <= 1'b1;
			repeat (3) @(posedge sys_clk);
			ext_clk <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
	endtask
endmodule // pin_source_model
`default_nettype wire
